// >>> shared/irq_map_pkg.sv
/*
 Package for the interrupt source and vector logic: source order, vector
 addresses, flag and enable positions, and the carrier structs.
 Assumes a single core clock and a synchronous active-high reset.
*/
package irq_map_pkg;

	// ----------------------------------------------------------------
	// Sources in fixed order within a level
	// ----------------------------------------------------------------
	localparam int NUM_SOURCES = 9;
	localparam int SRC_EXT0    = 0;
	localparam int SRC_TIMER0  = 1;
	localparam int SRC_EXT1    = 2;
	localparam int SRC_TIMER1  = 3;
	localparam int SRC_SERIAL0 = 4;
	localparam int SRC_TIMER2  = 5;
	localparam int SRC_SERIAL1 = 6;
	localparam int SRC_EXT2    = 7;
	localparam int SRC_EXT4    = 8;

	// ----------------------------------------------------------------
	// Vector addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] VEC_EXT0    = 16'h0003;
	localparam logic [15:0] VEC_TIMER0  = 16'h000b;
	localparam logic [15:0] VEC_EXT1    = 16'h0013;
	localparam logic [15:0] VEC_TIMER1  = 16'h001b;
	localparam logic [15:0] VEC_SERIAL0 = 16'h0023;
	localparam logic [15:0] VEC_TIMER2  = 16'h002b;
	localparam logic [15:0] VEC_SERIAL1 = 16'h003b;
	localparam logic [15:0] VEC_EXT2    = 16'h0043;
	localparam logic [15:0] VEC_EXT4    = 16'h0053;

	// ----------------------------------------------------------------
	// Flag positions in the extended flag register
	// ----------------------------------------------------------------
	localparam int EXT2_FLAG_BIT = 4;
	localparam int EXT4_FLAG_BIT = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [8:0]  PEND_RESET   = 9'h000;
	localparam logic [1:0]  LEVEL_RESET  = 2'h0;
	localparam logic [15:0] VECTOR_RESET = 16'h0000;

	// Level service state: idle, low routine running, high running
	typedef enum logic [1:0] {
		SVC_IDLE,
		SVC_LOW,
		SVC_HIGH
	} svc_state_e;

	// Raw flags as held by the peripheral control registers
	typedef struct packed {
		logic ext0_request_flag;
		logic timer0_overflow_flag;
		logic ext1_request_flag;
		logic timer1_overflow_flag;
		logic serial0_tx_done_flag;
		logic serial0_rx_done_flag;
		logic timer2_overflow_flag;
		logic timer2_ext_trigger_flag;
		logic serial1_tx_done_flag;
		logic serial1_rx_done_flag;
	} periph_flags_s;

	// Enable bits
	typedef struct packed {
		logic global_irq_enable;
		logic ext0_irq_enable;
		logic timer0_irq_enable;
		logic ext1_irq_enable;
		logic timer1_irq_enable;
		logic serial0_irq_enable;
		logic timer2_irq_enable;
		logic serial1_irq_enable;
		logic timer2_or_timer3_irq_enable;
		logic converter_ready_irq_enable;
	} irq_enables_s;

	// Priority bits, one per source, high level when set
	typedef struct packed {
		logic ext0_priority_bit;
		logic timer0_priority_bit;
		logic ext1_priority_bit;
		logic timer1_priority_bit;
		logic serial0_priority_bit;
		logic timer2_priority_bit;
		logic serial1_priority_bit;
		logic ext2_priority_bit;
		logic ext4_priority_bit;
	} irq_priority_s;

	// Request handed to the core
	typedef struct packed {
		logic        valid;
		logic        high_level;
		logic [3:0]  source;
		logic [15:0] vector;
	} irq_request_s;

endpackage

// >>> testbench/core_model.sv
/*
 Core model: takes a shown request and leaves each routine after a
 fixed time. Assumes requests are registered on the clk rising edge.
*/
`timescale 1ns/1ps

module core_model (
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic                      serve,
	input  wire irq_map_pkg::irq_request_s irq_request,
	output logic                           irq_taken,
	output logic                           irq_return
);
	int   depth;
	int   timer;
	logic take_now;
	logic return_now;

	// ----------------------------------------------------------------
	// Accept and return
	// ----------------------------------------------------------------
	initial begin
		irq_taken = 1'b0;
		irq_return = 1'b0;
	end

	// Skip a take while the last one is still being seen
	always @(posedge clk) begin
		take_now = 1'b0;
		return_now = 1'b0;
		if (reset) begin
			depth = 0;
			timer = 0;
		end else if (serve && irq_request.valid && !irq_taken) begin
			take_now = 1'b1;
			depth++;
			timer = 0;
		end else if (depth > 0 && ++timer == 20) begin
			return_now = 1'b1;
			depth--;
			timer = 0;
		end
		irq_taken <= take_now;
		irq_return <= return_now;
	end
endmodule

// >>> testbench/interrupt_source_vector_map_checker.sv
/*
 Checker for the interrupt source and vector logic, bound to its top.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module interrupt_source_vector_map_checker (
	input wire logic                      clk,
	input wire logic                      reset,
	input wire irq_map_pkg::irq_enables_s enables,
	input wire logic                      timer3_overflow,
	input wire logic                      converter_ready,
	input wire logic                      ext2_flag_clear,
	input wire logic                      ext4_flag_clear,
	input wire logic                      irq_taken,
	input wire irq_map_pkg::irq_request_s irq_request,
	input wire logic [7:0]                extended_flag_register,
	input wire logic [1:0]                active_level
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	// Slots 0..5 sit eight bytes apart, the last three do not
	function automatic logic [15:0] vec_of(input logic [3:0] s);
		return (s < 6) ? {9'h000, s, 3'b011} : (s == 6) ? 16'h003b :
			(s == 7) ? 16'h0043 : 16'h0053;
	endfunction

	sequence take_s;
		irq_taken && irq_request.valid;
	endsequence

	chk_reset_clears: assert property ($fell(reset) |-> irq_request == '0
		&& extended_flag_register == 8'h00 && active_level == 2'b00)
		else $error("outputs not clear after reset");
	chk_global_gate: assert property (
		!$past(enables.global_irq_enable) |-> !irq_request.valid)
		else $error("request while globally disabled");
	chk_vector_map: assert property (
		irq_request.valid |-> irq_request.vector == vec_of(irq_request.source))
		else $error("vector does not match source");
	chk_ext2_set: assert property (
		timer3_overflow |=> extended_flag_register[4])
		else $error("timer3 overflow did not set flag");
	chk_ext4_set: assert property (
		converter_ready |=> extended_flag_register[6])
		else $error("converter ready did not set flag");
	chk_ext2_clear: assert property (
		ext2_flag_clear && !timer3_overflow |=> !extended_flag_register[4])
		else $error("flag not cleared");
	chk_ext2_holds: assert property (
		extended_flag_register[4] && !ext2_flag_clear
		|=> extended_flag_register[4])
		else $error("flag lost without clear");
	chk_ext4_clear: assert property (
		ext4_flag_clear && !converter_ready |=> !extended_flag_register[6])
		else $error("converter flag not cleared");
	chk_spare_zero: assert property (
		(extended_flag_register & 8'haf) == 8'h00)
		else $error("spare flag bit set");
	chk_take_drops: assert property (
		take_s |=> !irq_request.valid && active_level[0])
		else $error("request not retired on take");
	chk_high_blocks: assert property (
		active_level[1] |-> !irq_request.valid)
		else $error("request shown inside high routine");
	chk_low_only_high: assert property (
		active_level == 2'b01 && irq_request.valid |-> irq_request.high_level)
		else $error("low request shown inside low routine");
endmodule

bind interrupt_source_vector_map interrupt_source_vector_map_checker
	interrupt_source_vector_map_checker_i (.clk, .reset, .enables,
	.timer3_overflow, .converter_ready, .ext2_flag_clear, .ext4_flag_clear,
	.irq_taken, .irq_request, .extended_flag_register, .active_level);

// >>> testbench/tb_interrupt_source_vector_map.sv
/*
 Testbench for the interrupt source and vector logic.
 Assumes the package, the core model and the bound checker.
*/
`timescale 1ns/1ps

module tb_interrupt_source_vector_map;
	logic                       clk = 1'b0;
	logic                       reset = 1'b1;
	logic                       serve = 1'b0;
	irq_map_pkg::periph_flags_s flags = '0;
	irq_map_pkg::irq_enables_s  enables = '0;
	irq_map_pkg::irq_priority_s priorities = '0;
	logic                       timer3_overflow = 1'b0;
	logic                       converter_ready = 1'b0;
	logic                       ext2_flag_clear = 1'b0;
	logic                       ext4_flag_clear = 1'b0;
	logic                       irq_taken;
	logic                       irq_return;
	irq_map_pkg::irq_request_s  irq_request;
	logic [7:0]                 extended_flag_register;
	logic [1:0]                 active_level;
	int                         fail_count = 0;
	int                         comparisons = 0;
	logic [9:0]  case_flag [12] = '{10'h200, 10'h100, 10'h080, 10'h040,
		10'h020, 10'h010, 10'h008, 10'h004, 10'h002, 10'h001, 0, 0};
	logic [8:0]  case_en [12] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010,
		9'h010, 9'h008, 9'h008, 9'h004, 9'h004, 9'h002, 9'h001};
	int          case_src [12] = '{0, 1, 2, 3, 4, 4, 5, 5, 6, 6, 7, 8};
	logic [15:0] vec [9] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
		16'h0023, 16'h002b, 16'h003b, 16'h0043, 16'h0053};

	interrupt_source_vector_map interrupt_source_vector_map_i (.clk, .reset,
		.flags, .enables, .priorities, .timer3_overflow, .converter_ready,
		.ext2_flag_clear, .ext4_flag_clear, .irq_taken, .irq_return,
		.irq_request, .extended_flag_register, .active_level);
	core_model core_model_i (.clk, .reset, .serve, .irq_request,
		.irq_taken, .irq_return);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task check(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task check_req(input logic [3:0] s);
		check(irq_request.valid === 1'b1 && irq_request.source === s
			&& irq_request.vector === vec[s], "wrong request");
	endtask

	task results;
		$display("Checks %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial forever #12.5 clk = ~clk;

	// Whole run is under 5 us; the limit leaves ample margin
	initial begin
		#50us;
		fail_count++;
		$display("[FAIL] %0t timeout", $time);
		results();
	end

	initial begin
		tick(6);
		reset = 1'b0;
		tick(1);
		check(irq_request === '0 && active_level === 2'b00, "reset");
		for (int k = 0; k < 12; k++) begin
			flags = case_flag[k];
			enables = {1'b1, case_en[k]};
			timer3_overflow = (k == 10);
			converter_ready = (k == 11);
			tick(1);
			timer3_overflow = 1'b0;
			converter_ready = 1'b0;
			tick(2);
			check_req(4'(case_src[k]));
			check(extended_flag_register === (k == 10 ? 8'h10 : k == 11 ?
				8'h40 : 8'h00), "flag register");
			flags = '0;
			ext2_flag_clear = (k == 10);
			ext4_flag_clear = (k == 11);
			tick(1);
			ext2_flag_clear = 1'b0;
			ext4_flag_clear = 1'b0;
			tick(2);
		end
		flags = '1;
		enables = 10'h1ff;
		timer3_overflow = 1'b1;
		converter_ready = 1'b1;
		tick(1);
		timer3_overflow = 1'b0;
		converter_ready = 1'b0;
		tick(2);
		check(irq_request.valid === 1'b0, "masked request");
		enables = '1;
		for (int s = 0; s < 9; s++) begin
			tick(2);
			check_req(4'(s));
			for (int k = 0; k < 12; k++)
				if (case_src[k] == s)
					flags = flags & ~case_flag[k];
			ext2_flag_clear = (s == 7);
			ext4_flag_clear = (s == 8);
			tick(1);
			ext2_flag_clear = 1'b0;
			ext4_flag_clear = 1'b0;
		end
		tick(2);
		check(irq_request.valid === 1'b0, "nothing left");
		priorities = 9'h080;
		flags.ext0_request_flag = 1'b1;
		serve = 1'b1;
		tick(3);
		check(active_level === 2'b01, "low entry");
		serve = 1'b0;
		flags = '0;
		flags.ext1_request_flag = 1'b1;
		tick(3);
		check(irq_request.valid === 1'b0, "equal level");
		flags.timer0_overflow_flag = 1'b1;
		tick(2);
		check_req(4'd1);
		check(irq_request.high_level === 1'b1, "level bit");
		serve = 1'b1;
		tick(3);
		check(active_level === 2'b11, "nested");
		serve = 1'b0;
		// High and low sources stay pending inside the high routine
		tick(3);
		check(irq_request.valid === 1'b0, "high blocks");
		flags = '0;
		tick(21);
		check(active_level === 2'b01, "resume low");
		tick(24);
		check(active_level === 2'b00, "all done");
		priorities = 9'h001;
		flags.ext0_request_flag = 1'b1;
		converter_ready = 1'b1;
		tick(1);
		converter_ready = 1'b0;
		tick(2);
		check_req(4'd8);
		check(irq_request.high_level === 1'b1, "high over low");
		results();
	end
endmodule

// >>> verilog/interrupt_source_vector_map.sv
/*
 Interrupt request logic: collects nine sources, holds the two internal
 extended flags, resolves two priority levels with fixed order inside a
 level, and presents one vectored request to the core.
 Assumes the core pulses irq_taken when it enters a routine and irq_return
 when it leaves one, and that peripheral flags are on the core clock.
*/
`timescale 1ns/1ps

module interrupt_source_vector_map (
	input  wire logic                         clk,
	input  wire logic                         reset,
	input  wire irq_map_pkg::periph_flags_s   flags,
	input  wire irq_map_pkg::irq_enables_s    enables,
	input  wire irq_map_pkg::irq_priority_s   priorities,
	input  wire logic                         timer3_overflow,
	input  wire logic                         converter_ready,
	input  wire logic                         ext2_flag_clear,
	input  wire logic                         ext4_flag_clear,
	input  wire logic                         irq_taken,
	input  wire logic                         irq_return,
	output irq_map_pkg::irq_request_s         irq_request,
	output logic [7:0]                        extended_flag_register,
	output logic [1:0]                        active_level
);

	// ------------------------------------------------------------------
	// Extended flags
	// ------------------------------------------------------------------
	logic ext2_flag;
	logic ext4_flag;
	logic next_ext2_flag;
	logic next_ext4_flag;
	logic [7:0] next_flag_register;

	always_comb begin
		next_ext2_flag = timer3_overflow | (ext2_flag & ~ext2_flag_clear);
		next_ext4_flag = converter_ready | (ext4_flag & ~ext4_flag_clear);
		next_flag_register = 8'h00;
		next_flag_register[irq_map_pkg::EXT2_FLAG_BIT] = next_ext2_flag;
		next_flag_register[irq_map_pkg::EXT4_FLAG_BIT] = next_ext4_flag;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ext2_flag              <= 1'b0;
			ext4_flag              <= 1'b0;
			extended_flag_register <= 8'h00;
		end else begin
			ext2_flag              <= next_ext2_flag;
			ext4_flag              <= next_ext4_flag;
			extended_flag_register <= next_flag_register;
		end
	end

	// ------------------------------------------------------------------
	// Gated requests
	// ------------------------------------------------------------------
	logic [8:0] raw;
	logic [8:0] gated;
	logic [8:0] prio;
	logic [8:0] high_req;
	logic [8:0] low_req;

	always_comb begin
		raw[irq_map_pkg::SRC_EXT0] =
			flags.ext0_request_flag & enables.ext0_irq_enable;
		raw[irq_map_pkg::SRC_TIMER0] =
			flags.timer0_overflow_flag & enables.timer0_irq_enable;
		raw[irq_map_pkg::SRC_EXT1] =
			flags.ext1_request_flag & enables.ext1_irq_enable;
		raw[irq_map_pkg::SRC_TIMER1] =
			flags.timer1_overflow_flag & enables.timer1_irq_enable;
		raw[irq_map_pkg::SRC_SERIAL0] = enables.serial0_irq_enable &
			(flags.serial0_tx_done_flag | flags.serial0_rx_done_flag);
		raw[irq_map_pkg::SRC_TIMER2] = enables.timer2_irq_enable &
			(flags.timer2_overflow_flag | flags.timer2_ext_trigger_flag);
		raw[irq_map_pkg::SRC_SERIAL1] = enables.serial1_irq_enable &
			(flags.serial1_tx_done_flag | flags.serial1_rx_done_flag);
		raw[irq_map_pkg::SRC_EXT2] =
			ext2_flag & enables.timer2_or_timer3_irq_enable;
		raw[irq_map_pkg::SRC_EXT4] =
			ext4_flag & enables.converter_ready_irq_enable;
		gated = enables.global_irq_enable ? raw : 9'h000;
		prio = {priorities.ext4_priority_bit,
			priorities.ext2_priority_bit,
			priorities.serial1_priority_bit,
			priorities.timer2_priority_bit,
			priorities.serial0_priority_bit,
			priorities.timer1_priority_bit,
			priorities.ext1_priority_bit,
			priorities.timer0_priority_bit,
			priorities.ext0_priority_bit};
		high_req = gated & prio;
		low_req  = gated & ~prio;
	end

	// ------------------------------------------------------------------
	// Fixed-order pick within each level
	// ------------------------------------------------------------------
	logic       high_found;
	logic       low_found;
	logic [3:0] high_index;
	logic [3:0] low_index;

	irq_pick #(.WIDTH(irq_map_pkg::NUM_SOURCES)) u_pick_high (
		.request (high_req),
		.found   (high_found),
		.index   (high_index)
	);

	irq_pick #(.WIDTH(irq_map_pkg::NUM_SOURCES)) u_pick_low (
		.request (low_req),
		.found   (low_found),
		.index   (low_index)
	);

	function automatic logic [15:0] vector_of(input logic [3:0] src);
		logic [15:0] v;
		v = irq_map_pkg::VEC_EXT4;
		unique case (src)
			4'h0: v = irq_map_pkg::VEC_EXT0;
			4'h1: v = irq_map_pkg::VEC_TIMER0;
			4'h2: v = irq_map_pkg::VEC_EXT1;
			4'h3: v = irq_map_pkg::VEC_TIMER1;
			4'h4: v = irq_map_pkg::VEC_SERIAL0;
			4'h5: v = irq_map_pkg::VEC_TIMER2;
			4'h6: v = irq_map_pkg::VEC_SERIAL1;
			4'h7: v = irq_map_pkg::VEC_EXT2;
			default: v = irq_map_pkg::VEC_EXT4;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------------
	// Level tracking and request output
	// ------------------------------------------------------------------
	// Nesting is at most two deep, so a low routine under a high one is
	// remembered by one bit rather than a stack.
	irq_map_pkg::svc_state_e  svc;
	irq_map_pkg::svc_state_e  next_svc;
	logic                     low_suspended;
	logic                     next_low_suspended;
	irq_map_pkg::irq_request_s next_request;
	logic [1:0]               next_active_level;

	always_comb begin
		next_svc           = svc;
		next_low_suspended = low_suspended;
		next_request       = '0;
		unique case (svc)
			irq_map_pkg::SVC_IDLE: begin
				if (high_found) begin
					next_request.valid      = 1'b1;
					next_request.high_level = 1'b1;
					next_request.source     = high_index;
					next_request.vector     = vector_of(high_index);
				end else if (low_found) begin
					next_request.valid  = 1'b1;
					next_request.source = low_index;
					next_request.vector = vector_of(low_index);
				end
			end
			irq_map_pkg::SVC_LOW: begin
				if (high_found) begin
					next_request.valid      = 1'b1;
					next_request.high_level = 1'b1;
					next_request.source     = high_index;
					next_request.vector     = vector_of(high_index);
				end
			end
			irq_map_pkg::SVC_HIGH: begin
				next_request = '0;
			end
		endcase
		if (irq_taken && irq_request.valid) begin
			next_request = '0;
			if (irq_request.high_level) begin
				next_svc           = irq_map_pkg::SVC_HIGH;
				next_low_suspended = (svc == irq_map_pkg::SVC_LOW);
			end else begin
				next_svc = irq_map_pkg::SVC_LOW;
			end
		end else if (irq_return) begin
			next_request = '0;
			if (svc == irq_map_pkg::SVC_HIGH && low_suspended) begin
				next_svc = irq_map_pkg::SVC_LOW;
			end else begin
				next_svc = irq_map_pkg::SVC_IDLE;
			end
			next_low_suspended = 1'b0;
		end
		next_active_level = {next_svc == irq_map_pkg::SVC_HIGH,
			next_svc != irq_map_pkg::SVC_IDLE};
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			svc                    <= irq_map_pkg::SVC_IDLE;
			low_suspended          <= 1'b0;
			irq_request            <= '0;
			active_level           <= irq_map_pkg::LEVEL_RESET;
		end else begin
			svc           <= next_svc;
			low_suspended <= next_low_suspended;
			irq_request   <= next_request;
			active_level  <= next_active_level;
		end
	end

endmodule

// >>> verilog/irq_pick.sv
/*
 Fixed-order picker: returns the lowest-numbered set bit of a request set.
 Pure combinational; the caller registers the result.
*/
`timescale 1ns/1ps

module irq_pick #(
	parameter int WIDTH = 9
) (
	input  wire logic [WIDTH-1:0] request,
	output logic                  found,
	output logic [3:0]            index
);

	// The index port is four bits wide, so at most sixteen requests
	if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
		$error("irq_pick WIDTH out of range");
	end

	// Scan from the top down so the lowest index is written last and wins
	always_comb begin
		found = 1'b0;
		index = 4'h0;
		for (int i = WIDTH - 1; i >= 0; i--) begin
			if (request[i]) begin
				found = 1'b1;
				index = 4'(i);
			end
		end
	end

endmodule
